// ==== logic/fus_pkg.sv ====
// package: register map, field layout, reset values and operation codes for the flash front end
package fus_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_KEY = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_OPADDR = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;

  // reset values
  localparam logic [31:0] RST_KEY = 32'h0000_0000;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [3:0] RST_OP = 4'h0;

  // control register layout
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned OP_W = 4;
  localparam int unsigned CTRL_START_BIT = 8;

  // status register layout
  localparam int unsigned STAT_VALID_BIT = 0;
  localparam int unsigned STAT_ERR_BIT = 1;
  localparam int unsigned STAT_KEY_BIT = 2;

  // operation codes carried in the operation-select field
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h1;
  localparam logic [3:0] OP_ROW_PROGRAM = 4'h2;
  localparam logic [3:0] OP_DWORD_PROGRAM = 4'h3;

  // low address bits disregarded per operation
  localparam int unsigned PAGE_IGNORE_BITS = 11;
  localparam int unsigned ROW_IGNORE_BITS = 8;
  localparam int unsigned DWORD_IGNORE_BITS = 2;
endpackage

// ==== logic/fus_addr_decode.sv ====
// target address decoder: masks and captures the address at the start of an operation
`timescale 1ns/1ps
module fus_addr_decode #(
  parameter int unsigned ADDR_BITS = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [fus_pkg::OP_W-1:0] op_select,
  input wire logic [ADDR_BITS-1:0] target_addr,
  output logic [ADDR_BITS-1:0] op_addr,
  output logic op_valid,
  output logic op_err
);
  // refused at elaboration: page masking needs more bits than it clears
  if (ADDR_BITS < fus_pkg::PAGE_IGNORE_BITS + 1) begin : g_width_check
    $error("address too narrow for page masking");
  end

  // clears the low bits that the selected operation disregards
  function automatic logic [ADDR_BITS-1:0] mask_for(input logic [fus_pkg::OP_W-1:0] op);
    logic [ADDR_BITS-1:0] ones;
    ones = '1;
    case (op)
      fus_pkg::OP_PAGE_ERASE: mask_for = ones << fus_pkg::PAGE_IGNORE_BITS;
      fus_pkg::OP_ROW_PROGRAM: mask_for = ones << fus_pkg::ROW_IGNORE_BITS;
      fus_pkg::OP_DWORD_PROGRAM: mask_for = ones << fus_pkg::DWORD_IGNORE_BITS;
      default: mask_for = '0;
    endcase
  endfunction

  function automatic logic op_known(input logic [fus_pkg::OP_W-1:0] op);
    op_known = (op == fus_pkg::OP_PAGE_ERASE) || (op == fus_pkg::OP_ROW_PROGRAM) ||
      (op == fus_pkg::OP_DWORD_PROGRAM);
  endfunction

  logic [ADDR_BITS-1:0] addr_reg;
  logic [ADDR_BITS-1:0] addr_next;
  logic valid_reg;
  logic valid_next;
  logic err_reg;
  logic err_next;

  always_comb begin
    addr_next = addr_reg;
    valid_next = 1'b0;
    err_next = err_reg;
    if (start) begin
      // the select value of this very cycle decides the masking
      err_next = !op_known(op_select);
      valid_next = op_known(op_select);
      if (op_known(op_select)) begin
        addr_next = target_addr & mask_for(op_select);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_reg <= '0;
      valid_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      valid_reg <= valid_next;
      err_reg <= err_next;
    end
  end

  assign op_addr = addr_reg;
  assign op_valid = valid_reg;
  assign op_err = err_reg;
endmodule

// ==== logic/fus_regs.sv ====
// flash front end: unlock key and target address registers on an apb slave
`timescale 1ns/1ps
// Overview of operation
// - key register takes the written byte lanes whose pstrb bit is set; reads of it always give zero
// - target address is 32-bit read/write and clears to zero at reset
// - page erase ignores address bits 10:0
// - row program ignores address bits 7:0
// - double-word program selects a 32-bit location, ignoring address bits 1:0
// - key register is 32-bit write-only and resets to zero
module fus_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fus_pkg::ADDR_W-1:0] paddr,
  input wire logic [fus_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [fus_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  output logic [fus_pkg::DATA_W-1:0] unlock_key,
  output logic unlock_key_written,
  output logic [fus_pkg::OP_W-1:0] op_select,
  output logic [fus_pkg::DATA_W-1:0] op_addr,
  output logic op_start,
  output logic op_valid,
  output logic op_err
);
  localparam int unsigned DW = fus_pkg::DATA_W;

  function automatic logic [DW-1:0] apply_strobes(input logic [DW-1:0] old_v, input logic [DW-1:0] new_v,
      input logic [3:0] strb);
    logic [DW-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    apply_strobes = res;
  endfunction

  function automatic logic is_mapped(input logic [fus_pkg::ADDR_W-1:0] a);
    is_mapped = (a == fus_pkg::OFS_KEY) || (a == fus_pkg::OFS_ADDR) || (a == fus_pkg::OFS_CTRL) ||
      (a == fus_pkg::OFS_OPADDR) || (a == fus_pkg::OFS_STATUS);
  endfunction

  logic access;
  logic wr_en;
  logic rd_en;

  logic [DW-1:0] key_reg;
  logic [DW-1:0] key_next;
  logic key_wr_reg;
  logic key_wr_next;
  logic key_seen_reg;
  logic key_seen_next;
  logic [DW-1:0] addr_reg;
  logic [DW-1:0] addr_next;
  logic [fus_pkg::OP_W-1:0] op_reg;
  logic [fus_pkg::OP_W-1:0] op_next;
  logic start_reg;
  logic start_next;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;
  logic err_reg;
  logic err_next;

  logic [DW-1:0] dec_addr;
  logic dec_valid;
  logic dec_err;
  logic valid_seen_reg;
  logic valid_seen_next;

  // zero wait states: every access completes in its first access cycle
  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign pready = 1'b1;

  // register writes
  always_comb begin
    key_next = key_reg;
    key_wr_next = 1'b0;
    key_seen_next = key_seen_reg;
    addr_next = addr_reg;
    op_next = op_reg;
    start_next = 1'b0;
    if (wr_en) begin
      case (paddr)
        fus_pkg::OFS_KEY: begin
          key_next = apply_strobes(key_reg, pwdata, pstrb);
          key_wr_next = 1'b1;
          key_seen_next = 1'b1;
        end
        fus_pkg::OFS_ADDR: begin
          addr_next = apply_strobes(addr_reg, pwdata, pstrb);
        end
        fus_pkg::OFS_CTRL: begin
          if (pstrb[0]) begin
            op_next = pwdata[fus_pkg::CTRL_OP_LSB +: fus_pkg::OP_W];
          end
          // start uses the select value written in the same access
          if (pstrb[1]) begin
            start_next = pwdata[fus_pkg::CTRL_START_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_reg <= fus_pkg::RST_KEY;
      key_wr_reg <= 1'b0;
      key_seen_reg <= 1'b0;
      addr_reg <= fus_pkg::RST_ADDR;
      op_reg <= fus_pkg::RST_OP;
      start_reg <= 1'b0;
    end else begin
      key_reg <= key_next;
      key_wr_reg <= key_wr_next;
      key_seen_reg <= key_seen_next;
      addr_reg <= addr_next;
      op_reg <= op_next;
      start_reg <= start_next;
    end
  end

  // read data and error are registered in the access cycle, so they follow one cycle later;
  // prdata is therefore taken combinationally below from the decode of the same cycle
  always_comb begin
    rdata_next = '0;
    err_next = 1'b0;
    if (access && !is_mapped(paddr)) begin
      err_next = 1'b1;
    end
    if (rd_en) begin
      case (paddr)
        fus_pkg::OFS_KEY: rdata_next = '0;
        fus_pkg::OFS_ADDR: rdata_next = addr_reg;
        fus_pkg::OFS_CTRL: rdata_next[fus_pkg::CTRL_OP_LSB +: fus_pkg::OP_W] = op_reg;
        fus_pkg::OFS_OPADDR: rdata_next = dec_addr;
        fus_pkg::OFS_STATUS: begin
          rdata_next[fus_pkg::STAT_VALID_BIT] = valid_seen_reg;
          rdata_next[fus_pkg::STAT_ERR_BIT] = dec_err;
          rdata_next[fus_pkg::STAT_KEY_BIT] = key_seen_reg;
        end
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  // answer is valid in the access cycle itself; in the next cycle prdata gives the registered copy, then zero, and pslverr is zero
  assign prdata = access ? rdata_next : rdata_reg;
  assign pslverr = access ? err_next : 1'b0;

  // a valid capture is sticky until the next start; a new capture in the same cycle wins
  always_comb begin
    valid_seen_next = valid_seen_reg;
    if (start_reg) begin
      valid_seen_next = 1'b0;
    end
    if (dec_valid) begin
      valid_seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_seen_reg <= 1'b0;
    end else begin
      valid_seen_reg <= valid_seen_next;
    end
  end

  fus_addr_decode #(
    .ADDR_BITS(DW)
  ) u_decode (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start_reg),
    .op_select(op_reg),
    .target_addr(addr_reg),
    .op_addr(dec_addr),
    .op_valid(dec_valid),
    .op_err(dec_err)
  );

  assign unlock_key = key_reg;
  assign unlock_key_written = key_wr_reg;
  assign op_select = op_reg;
  assign op_start = start_reg;
  assign op_addr = dec_addr;
  assign op_valid = dec_valid;
  assign op_err = dec_err;
endmodule

// ==== tb/fus_regs_asserts.sv ====
// checker: key, address and operation rules at the ports of the flash front end
`timescale 1ns/1ps
module fus_regs_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [31:0] unlock_key,
  input wire logic unlock_key_written,
  input wire logic [3:0] op_select,
  input wire logic [31:0] op_addr,
  input wire logic op_start,
  input wire logic op_valid,
  input wire logic op_err
);
  logic [31:0] shadow_reg;
  logic [31:0] shadow_next;
  logic rd;
  logic wr;
  logic wr_any;
  assign rd = psel && penable && !pwrite;
  assign wr_any = psel && penable && pwrite;
  assign wr = wr_any && pstrb == 4'hf;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // shadow follows byte strobes so partial writes keep it in step
  always_comb begin
    shadow_next = shadow_reg;
    if (wr_any && paddr == fus_pkg::OFS_ADDR) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          shadow_next[i*8 +: 8] = pwdata[i*8 +: 8];
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow_reg <= 32'h0;
    end else begin
      shadow_reg <= shadow_next;
    end
  end
  chk_key_reads_zero: assert property (rd && paddr == fus_pkg::OFS_KEY |-> prdata == 32'h0)
    else $error("key read not zero");
  chk_addr_read_back: assert property (rd && paddr == fus_pkg::OFS_ADDR |-> prdata == shadow_reg)
    else $error("address read back wrong");
  chk_key_capture: assert property (
    wr && paddr == fus_pkg::OFS_KEY |=> unlock_key == $past(pwdata) && unlock_key_written)
    else $error("key not captured");
  chk_page_mask: assert property (
    op_start && op_select == fus_pkg::OP_PAGE_ERASE |=>
    op_valid && op_addr == ($past(shadow_reg) & 32'hffff_f800))
    else $error("page address wrong");
  chk_row_mask: assert property (
    op_start && op_select == fus_pkg::OP_ROW_PROGRAM |=>
    op_valid && op_addr == ($past(shadow_reg) & 32'hffff_ff00))
    else $error("row address wrong");
  chk_dword_mask: assert property (
    op_start && op_select == fus_pkg::OP_DWORD_PROGRAM |=>
    op_valid && op_addr == ($past(shadow_reg) & 32'hffff_fffc))
    else $error("double-word address wrong");
  chk_unknown_op: assert property (
    op_start && (op_select == fus_pkg::OP_NONE || op_select > fus_pkg::OP_DWORD_PROGRAM) |=>
    op_err && !op_valid)
    else $error("unknown op not flagged");
endmodule
bind fus_regs fus_regs_asserts u_fus_regs_asserts (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .unlock_key(unlock_key),
  .unlock_key_written(unlock_key_written), .op_select(op_select), .op_addr(op_addr), .op_start(op_start),
  .op_valid(op_valid), .op_err(op_err));

// ==== tb/fus_regs_tb.sv ====
// testbench: apb traffic to key and address registers, operation address masking
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module fus_regs_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] rd, a, k, ea, prdata, ukey, opa;
  logic [3:0] op, osel;
  logic pready, pslverr, ukw, ops, opv, ope, err;
  logic [31:0] b;
  logic [3:0] s;
  logic kn;
  int bad_count = 0;
  int samples_checked = 0;
  int n;
  always #5 clk = ~clk;
  fus_regs u_fus_regs (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .unlock_key(ukey),
    .unlock_key_written(ukw), .op_select(osel), .op_addr(opa), .op_start(ops), .op_valid(opv), .op_err(ope));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // request held from setup until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // byte lanes with their strobe set take the new value, the others keep the old one
  function automatic logic [31:0] exp_strb(input logic [31:0] o, input logic [31:0] v, input logic [3:0] st);
    exp_strb = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        exp_strb[i*8 +: 8] = v[i*8 +: 8];
      end
    end
  endfunction
  function automatic logic [31:0] exp_mask(input logic [3:0] o, input logic [31:0] v, input logic [31:0] p);
    case (o)
      fus_pkg::OP_PAGE_ERASE: return v & 32'hffff_f800;
      fus_pkg::OP_ROW_PROGRAM: return v & 32'hffff_ff00;
      fus_pkg::OP_DWORD_PROGRAM: return v & 32'hffff_fffc;
      default: return p;
    endcase
  endfunction
  initial begin
    n = $urandom(49);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(0, fus_pkg::OFS_ADDR, 0);
    `CHK("addr reset", 32'h0, rd)
    `CHK("key reset", 32'h0, ukey)
    $display("test reset done");
    for (n = 0; n < 8; n++) begin
      k = (n == 0) ? 32'hffff_ffff : $urandom;
      a = $urandom;
      xfer(1, fus_pkg::OFS_KEY, k);
      xfer(0, fus_pkg::OFS_KEY, 0);
      `CHK("key read", 32'h0, rd)
      `CHK("key read err", 1'b0, err)
      `CHK("key held", k, ukey)
      xfer(1, fus_pkg::OFS_ADDR, a);
      xfer(0, fus_pkg::OFS_ADDR, 0);
      `CHK("addr read", a, rd)
      // partial strobes: a zero strobe is the corner that must change nothing
      b = $urandom;
      s = (n == 0) ? 4'h0 : 4'($urandom);
      pstrb <= s;
      xfer(1, fus_pkg::OFS_ADDR, b);
      pstrb <= 4'hf;
      xfer(0, fus_pkg::OFS_ADDR, 0);
      `CHK("addr strobe", exp_strb(a, b, s), rd)
    end
    $display("test registers done");
    ea = 32'h0;
    for (n = 0; n < 16; n++) begin
      op = (n == 3) ? 4'h0 : (n % 4 == 3) ? 4'(4 + $urandom_range(11)) : 4'(n % 4 + 1);
      kn = (op != 4'h0) && (op < 4'h4);
      a = (n < 4) ? 32'hffff_ffff : $urandom;
      xfer(1, fus_pkg::OFS_ADDR, a);
      // op field and start in one write: the new op must decide the mask
      xfer(1, fus_pkg::OFS_CTRL, {23'h0, 1'b1, 4'h0, op});
      ea = exp_mask(op, a, ea);
      // op_valid stands only in the cycle after op_start
      @(posedge clk);
      #1;
      `CHK("op select", op, osel)
      `CHK("op valid", kn, opv)
      `CHK("op err", !kn, ope)
      `CHK("op addr", ea, opa)
      xfer(0, fus_pkg::OFS_OPADDR, 0);
      `CHK("op addr read", ea, rd)
      xfer(0, fus_pkg::OFS_STATUS, 0);
      `CHK("status read", {29'h0, 1'b1, !kn, kn}, rd)
    end
    $display("test operations done");
    xfer(1, 8'h04, $urandom);
    `CHK("unmapped write err", 1'b1, err)
    xfer(0, 8'h04, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped read", 32'h0, rd)
    xfer(0, fus_pkg::OFS_ADDR, 0);
    `CHK("addr kept", a, rd)
    $display("test unmapped done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(0, fus_pkg::OFS_ADDR, 0);
    `CHK("addr rearm", 32'h0, rd)
    `CHK("key rearm", 32'h0, ukey)
    $display("test reset again done");
    complete_run();
  end
endmodule
